/* File: ucms_defs.vh */
// constants for the universal counter measurement sequencer
// assumes inclusion by ucms_top.v and by the test bench
`ifndef UCMS_DEFS_VH
`define UCMS_DEFS_VH
// ==========================================================
// register byte offsets
`define UCMS_OFF_CTRL 8'h00
`define UCMS_OFF_GATE 8'h04
`define UCMS_OFF_CMD 8'h08
`define UCMS_OFF_STATUS 8'h0c
`define UCMS_OFF_EVENTS 8'h10
`define UCMS_OFF_CYCLES 8'h14
// ==========================================================
// control field positions
`define UCMS_CTRL_FUNC_LO 0
`define UCMS_CTRL_FUNC_HI 2
`define UCMS_CTRL_SHARED 3
`define UCMS_CTRL_EXT_ARM 4
`define UCMS_CTRL_STOP_ARM_OFF 5
`define UCMS_CTRL_ONE_SHOT 6
`define UCMS_CTRL_AVG100 7
`define UCMS_CTRL_AUTOMATIC_TRIGGER_LEVEL 8
`define UCMS_CTRL_AUTO_ATTEN 9
`define UCMS_CTRL_SENSITIVITY_MODE 10
`define UCMS_CTRL_SLOPE_A 11
`define UCMS_CTRL_SLOPE_B 12
`define UCMS_CTRL_MASK 32'h00001fff
// ==========================================================
// function codes
`define UCMS_FN_FREQUENCY_FIRST_INPUT 3'h0
`define UCMS_FN_FREQUENCY_SECOND_INPUT 3'h1
`define UCMS_FN_FREQUENCY_THIRD_INPUT 3'h2
`define UCMS_FN_PERIOD_A 3'h3
`define UCMS_FN_TI 3'h4
// ==========================================================
// reset values: frequency on first input, auto trigger and auto attenuation on
`define UCMS_CTRL_RESET 32'h00000300
`define UCMS_GATE_RESET_MS 17'h0012c
// gate limits in milliseconds: 1 .. 99999
`define UCMS_GATE_MIN_MS 17'h00001
`define UCMS_GATE_MAX_MS 17'h1869f
// ==========================================================
// timing: clock rate and one millisecond
`define UCMS_CLK_HZ 250000000
`define UCMS_MS_PER_S 1000
`define UCMS_MS_CYCLES (`UCMS_CLK_HZ / `UCMS_MS_PER_S)
// averaging count for interval averaging
`define UCMS_AVG_COUNT 7'h64
`endif

/* File: ucms_properties.sv */
// checker for the sequencer's bus handshake and result pulse
// assumes bind onto ucms_top; single clock mclk, synchronous reset rst
`default_nettype none
module ucms_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic automatic_trigger_level,
    input wire logic automatic_attenuation,
    input wire logic result_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ==========================================================
    // responses stand until taken
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed before rready");
    // answers one cycle after acceptance
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    // no new request while a response stands
    chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    chk_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    // ==========================================================
    // power-up state and result pulse
    chk_reset_autos: assert property ($fell(rst) |-> automatic_trigger_level && automatic_attenuation)
        else $error("automatic trigger or attenuation off after reset");
    chk_strobe_pulse: assert property (result_strobe |=> !result_strobe)
        else $error("result pulse longer than one cycle");
endmodule // ucms_chk
bind ucms_top ucms_chk chk_u (.mclk(mclk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .automatic_trigger_level(automatic_trigger_level), .automatic_attenuation(automatic_attenuation),
    .result_strobe(result_strobe));
`default_nettype wire

/* File: ucms_sig_gen.sv */
// model of the digitised comparator and arm levels feeding the sequencer
// assumes a free-running mclk; all waves derive from one cycle counter
`default_nettype none
module ucms_sig_gen (
    input wire logic mclk,
    input wire logic [31:0] half_a, // half period, first input
    input wire logic [31:0] half_b, // half period, second input
    input wire logic [31:0] lag_b, // second input delay, below 2*half_b
    input wire logic [31:0] arm_per, // arm pulse spacing
    input wire logic arm_en, // arm pulses on
    output wire logic trig_a,
    output wire logic trig_b,
    output wire logic trig_c,
    output wire logic ext_arm
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cnt_r = 32'h0; // free cycle count
    // ==========================================================
    // counter changes just after each edge
    always @(posedge mclk)
        cnt_r <= cnt_r + 32'h1;
    // square waves; third input fixed at four cycles
    assign trig_a = (cnt_r % (32'h2 * half_a)) >= half_a;
    assign trig_b = ((cnt_r + 32'h2 * half_b - lag_b) % (32'h2 * half_b)) >= half_b;
    assign trig_c = cnt_r[1];
    assign ext_arm = arm_en && (cnt_r % arm_per) == 32'h0; // one-cycle arm pulse
endmodule // ucms_sig_gen
`default_nettype wire

/* File: ucms_top.v */
// measurement sequencer of a three-input universal counter with axi4-lite registers
// assumes trigger inputs are digitised comparator levels synchronous to mclk
//
// Behaviour
// - gate interval 1 ms to 99.999 s
// - reset: frequency first input, 300 ms, autos on
// - without external arm, signal arms itself continuously
// - period mode averages whole periods within gate unless external arm also stops it
// - interval runs first-input start to second-input stop
// - shared input feeds both channels from first
// - channels a and b keep own slope settings
// - slope bit picks rising or falling edge
// - arming by gate and signal, or external
// - stop arming can fall back to gate
// - interval sets gate; setting sets spacing
// - one-shot: one measurement per reset command
// - hundred-gate averaging sums repeated intervals
// - counters wide enough for nine digits
// - frequency selectable on first, second, third input
`include "ucms_defs.vh"
`default_nettype none
module ucms_top #(
    parameter MS_CYCLES = `UCMS_MS_CYCLES, // cycles per millisecond
    parameter CW = 40 // result counter width
) (
    input wire mclk,
    input wire rst,
    input wire trig_a, // channel a comparator level
    input wire trig_b, // channel b comparator level
    input wire trig_c, // high-frequency channel level
    input wire ext_arm, // external arm level
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output wire automatic_trigger_level,
    output wire automatic_attenuation,
    output wire sensitivity_mode,
    output reg result_strobe // one cycle when a result is published
);
    // ==========================================================
    // helpers
    // selected edge of a level, fall picks the falling edge
    function sel_edge(input cur, input prev, input fall);
        begin
            sel_edge = fall ? (prev & ~cur) : (cur & ~prev);
        end
    endfunction
    // byte-lane merge of a write into a word
    function [31:0] merge(input [31:0] old, input [31:0] wd, input [3:0] st);
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (st[i])
                    merge[i*8 +: 8] = wd[i*8 +: 8];
        end
    endfunction
    // ==========================================================
    // state encoding, one-hot
    localparam [4:0] ST_IDLE = 5'h01; // one-shot waiting for command
    localparam [4:0] ST_ARM = 5'h02; // waiting for arming
    localparam [4:0] ST_WSTART = 5'h04; // waiting for start edge
    localparam [4:0] ST_MEAS = 5'h08; // gate open
    localparam [4:0] ST_HOLD = 5'h10; // spacing between intervals
    // ==========================================================
    // registers and state
    reg [31:0] ctrl_r; // control word
    reg [16:0] gate_ms_r; // gate interval in ms
    reg [CW-1:0] res_events_r; // published event or period count
    reg [CW-1:0] res_cycles_r; // published timebase cycles
    reg [15:0] res_seq_r; // result sequence number
    reg [4:0] state_r;
    reg [3:0] prev_r; // previous levels: arm, c, b, a
    reg [31:0] ms_div_r; // millisecond divider
    reg [16:0] ms_cnt_r; // elapsed ms since timer restart
    reg [CW-1:0] events_r; // edges counted in gate
    reg [CW-1:0] cycles_r; // cycles counted in gate
    reg [6:0] avg_n_r; // intervals taken in averaging
    reg aw_held_r; // write address taken
    reg w_held_r; // write data taken
    reg [7:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg cmd_restart; // restart pulse from command write
    // ==========================================================
    // control decode
    wire [2:0] func = ctrl_r[`UCMS_CTRL_FUNC_HI:`UCMS_CTRL_FUNC_LO];
    wire is_ti = (func == `UCMS_FN_TI);
    wire is_per = (func == `UCMS_FN_PERIOD_A);
    wire shared = ctrl_r[`UCMS_CTRL_SHARED];
    wire ext_on = ctrl_r[`UCMS_CTRL_EXT_ARM];
    wire stop_gate = ctrl_r[`UCMS_CTRL_STOP_ARM_OFF]; // stop armed by gate
    wire one_shot = ctrl_r[`UCMS_CTRL_ONE_SHOT];
    wire avg100 = ctrl_r[`UCMS_CTRL_AVG100];
    assign automatic_trigger_level = ctrl_r[`UCMS_CTRL_AUTOMATIC_TRIGGER_LEVEL];
    assign automatic_attenuation = ctrl_r[`UCMS_CTRL_AUTO_ATTEN];
    assign sensitivity_mode = ctrl_r[`UCMS_CTRL_SENSITIVITY_MODE];
    // ==========================================================
    // channel routing and edge detection
    wire chan_b = shared ? trig_a : trig_b;
    wire [3:0] lvl = {ext_arm, trig_c, chan_b, trig_a};
    // each channel keeps its own slope bit in both routings
    wire edge_a = sel_edge(trig_a, prev_r[0], ctrl_r[`UCMS_CTRL_SLOPE_A]);
    wire edge_b = sel_edge(chan_b, prev_r[1], ctrl_r[`UCMS_CTRL_SLOPE_B]);
    wire edge_c = sel_edge(trig_c, prev_r[2], 1'b0);
    wire arm_edge = sel_edge(ext_arm, prev_r[3], 1'b0);
    // measured channel for frequency and period
    wire meas_edge = (func == `UCMS_FN_FREQUENCY_SECOND_INPUT) ? edge_b : (func == `UCMS_FN_FREQUENCY_THIRD_INPUT) ? edge_c : edge_a;
    wire gate_done = (ms_cnt_r >= gate_ms_r);
    // ==========================================================
    // level history, loaded in reset too so no false edge follows it
    always @(posedge mclk)
        prev_r <= lvl;
    // ==========================================================
    // axi4-lite write channel
    assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
    wire aw_fire = s_axi_awvalid & s_axi_awready;
    wire w_fire = s_axi_wvalid & s_axi_wready;
    wire aw_have = aw_held_r | aw_fire;
    wire w_have = w_held_r | w_fire;
    wire [7:0] wa = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wd = w_held_r ? w_data_r : s_axi_wdata;
    wire [3:0] ws = w_held_r ? w_strb_r : s_axi_wstrb;
    wire do_write = aw_have & w_have & ~s_axi_bvalid;
    wire [31:0] gate_merged = merge({15'h0000, gate_ms_r}, wd, ws);
    // address and data may arrive in either order
    always @(posedge mclk)
    begin
        if (rst)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            ctrl_r <= `UCMS_CTRL_RESET;
            gate_ms_r <= `UCMS_GATE_RESET_MS;
            cmd_restart <= 1'b0;
        end
        else
        begin
            cmd_restart <= 1'b0;
            if (aw_fire)
                aw_addr_r <= s_axi_awaddr;
            if (w_fire)
            begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                case ({wa[7:2], 2'h0})
                    `UCMS_OFF_CTRL: ctrl_r <= merge(ctrl_r, wd, ws) & `UCMS_CTRL_MASK;
                    `UCMS_OFF_GATE:
                    begin
                        // clamp to the 1 ms .. 99.999 s range
                        if (gate_merged[31:17] != 15'h0000 || gate_merged[16:0] > `UCMS_GATE_MAX_MS)
                            gate_ms_r <= `UCMS_GATE_MAX_MS;
                        else if (gate_merged[16:0] < `UCMS_GATE_MIN_MS)
                            gate_ms_r <= `UCMS_GATE_MIN_MS;
                        else
                            gate_ms_r <= gate_merged[16:0];
                    end
                    `UCMS_OFF_CMD: cmd_restart <= ws[0] & wd[0];
                    `UCMS_OFF_STATUS, `UCMS_OFF_EVENTS, `UCMS_OFF_CYCLES: ;
                    default: s_axi_bresp <= 2'h2; // unmapped: slave error
                endcase
            end
            else
            begin
                if (aw_fire)
                    aw_held_r <= 1'b1;
                if (w_fire)
                    w_held_r <= 1'b1;
                if (s_axi_bvalid & s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
        end
    end
    // ==========================================================
    // axi4-lite read channel, answer one cycle after address
    assign s_axi_arready = ~s_axi_rvalid;
    always @(posedge mclk)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end
        else if (s_axi_arvalid & s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h00000000;
            case ({s_axi_araddr[7:2], 2'h0})
                `UCMS_OFF_CTRL: s_axi_rdata <= ctrl_r;
                `UCMS_OFF_GATE: s_axi_rdata <= {15'h0000, gate_ms_r};
                `UCMS_OFF_CMD: ;
                `UCMS_OFF_STATUS: s_axi_rdata <= {res_seq_r, 4'h0, avg_n_r, state_r};
                `UCMS_OFF_EVENTS: s_axi_rdata <= res_events_r[31:0];
                `UCMS_OFF_CYCLES: s_axi_rdata <= res_cycles_r[31:0];
                default: s_axi_rresp <= 2'h2; // unmapped: slave error
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
    // ==========================================================
    // measurement sequencer
    // gate timer counts whole ms from its own restart so spacing is exact
    wire timer_restart = (state_r == ST_WSTART) | (state_r == ST_ARM);
    always @(posedge mclk)
    begin
        if (rst || timer_restart)
        begin
            ms_div_r <= 32'h00000000;
            ms_cnt_r <= 17'h00000;
        end
        else if (ms_div_r == MS_CYCLES - 1)
        begin
            ms_div_r <= 32'h00000000;
            if (!gate_done)
                ms_cnt_r <= ms_cnt_r + 17'h00001;
        end
        else
            ms_div_r <= ms_div_r + 32'h00000001;
    end
    // close condition of an open gate
    wire close = is_ti ? edge_b :
                 (ext_on && !stop_gate) ? arm_edge :
                 is_per ? (gate_done & meas_edge) :
                 gate_done;
    // sequencing: arm, start, measure, publish, space
    always @(posedge mclk)
    begin
        if (rst)
        begin
            state_r <= ST_ARM;
            events_r <= {CW{1'b0}};
            cycles_r <= {CW{1'b0}};
            avg_n_r <= 7'h00;
            res_events_r <= {CW{1'b0}};
            res_cycles_r <= {CW{1'b0}};
            res_seq_r <= 16'h0000;
            result_strobe <= 1'b0;
        end
        else
        begin
            result_strobe <= 1'b0;
            if (cmd_restart)
            begin
                // reset command: clear and take a fresh measurement
                state_r <= ST_ARM;
                avg_n_r <= 7'h00;
                events_r <= {CW{1'b0}};
                cycles_r <= {CW{1'b0}};
            end
            else
            begin
                case (state_r)
                    ST_IDLE:
                        if (!one_shot)
                            state_r <= ST_ARM;
                    ST_ARM:
                        // self arm immediately, or wait for arm input
                        if (!ext_on || arm_edge)
                            state_r <= ST_WSTART;
                    ST_WSTART:
                        if ((is_ti && edge_a) || (!is_ti && meas_edge))
                        begin
                            state_r <= ST_MEAS;
                            if (!(is_ti && avg100 && avg_n_r != 7'h00))
                                cycles_r <= {CW{1'b0}};
                            events_r <= {CW{1'b0}};
                        end
                    ST_MEAS:
                    begin
                        // count cycles and edges while the gate is open
                        cycles_r <= cycles_r + {{(CW-1){1'b0}}, 1'b1};
                        if ((!is_ti && meas_edge && !close) || (is_per && close))
                            events_r <= events_r + {{(CW-1){1'b0}}, 1'b1};
                        if (close)
                        begin
                            if (is_ti && avg100 && avg_n_r != `UCMS_AVG_COUNT - 7'h01)
                            begin
                                avg_n_r <= avg_n_r + 7'h01;
                                state_r <= ST_WSTART;
                            end
                            else
                            begin
                                res_cycles_r <= (is_ti || is_per) ? cycles_r + {{(CW-1){1'b0}}, 1'b1}
                                                                  : cycles_r;
                                res_events_r <= is_ti ? (avg100 ? {{(CW-7){1'b0}}, `UCMS_AVG_COUNT}
                                                                : {{(CW-1){1'b0}}, 1'b1})
                                                      : (is_per ? events_r + {{(CW-1){1'b0}}, 1'b1}
                                                                : events_r);
                                res_seq_r <= res_seq_r + 16'h0001;
                                result_strobe <= 1'b1;
                                avg_n_r <= 7'h00;
                                if (one_shot)
                                    state_r <= ST_IDLE;
                                else if (is_ti)
                                    state_r <= ST_HOLD;
                                else
                                    state_r <= ST_ARM;
                            end
                        end
                    end
                    ST_HOLD:
                        // gate setting only spaces successive intervals
                        if (gate_done)
                            state_r <= ST_ARM;
                    default: state_r <= ST_ARM;
                endcase
            end
        end
    end
endmodule // ucms_top
`default_nettype wire

/* File: universal_counter_measure_seq_test.sv */
// self-checking bench for the counter sequencer
// assumes ucms_top, ucms_sig_gen and the bound checker; one millisecond shortened to 10 cycles
`include "ucms_defs.vh"
`default_nettype none
module universal_counter_measure_seq_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, ev, cy, rdv, ha = 32'h3, hb = 32'h5, lag = 32'h0, aper = 32'h64;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic aen = 1'b0, got;
    logic [1:0] rsp;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, result_strobe;
    wire logic trig_a, trig_b, trig_c, ext_arm, automatic_trigger_level, automatic_attenuation, sensitivity_mode;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    int err_count = 0, checks_done = 0, gap;
    always #2 mclk = ~mclk;
    ucms_top #(.MS_CYCLES(10)) dut_u (.mclk(mclk), .rst(rst), .trig_a(trig_a), .trig_b(trig_b), .trig_c(trig_c),
        .ext_arm(ext_arm), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .automatic_trigger_level(automatic_trigger_level), .automatic_attenuation(automatic_attenuation),
        .sensitivity_mode(sensitivity_mode), .result_strobe(result_strobe));
    ucms_sig_gen sig_u (.mclk(mclk), .half_a(ha), .half_b(hb), .lag_b(lag), .arm_per(aper), .arm_en(aen),
        .trig_a(trig_a), .trig_b(trig_b), .trig_c(trig_c), .ext_arm(ext_arm));
    // ==========================================================
    // verdict and comparisons
    task automatic complete_run;
        if (err_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_in(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
        checks_done++;
        if ((g >= lo && g <= hi) !== 1'b1)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h to %h", $time, g, lo, hi);
        end
    endtask
    // ==========================================================
    // bus cycles: hold each channel until its ready, wait bounded for the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++)
        begin
            @(posedge mclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        if (n >= 50) begin err_count++; complete_run(); end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        @(posedge mclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++)
        begin
            @(posedge mclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        if (n >= 50) begin err_count++; complete_run(); end
        {d, rsp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
    // waits up to lim cycles for a result pulse, reports cycles spent
    task automatic ws(input int lim, output logic f, output int c);
        f = 1'b0;
        for (c = 0; c < lim && !f; c++)
        begin
            @(posedge mclk);
            f = (result_strobe === 1'b1);
        end
    endtask
    // set up, restart, drop the first result, read the second
    task automatic measure(input logic [31:0] ctrl, input logic [31:0] gate);
        wr(`UCMS_OFF_GATE, gate);
        wr(`UCMS_OFF_CTRL, ctrl);
        wr(`UCMS_OFF_CMD, 32'h1);
        ws(20000, got, gap);
        ws(20000, got, gap);
        if (!got) begin err_count++; complete_run(); end
        rd(`UCMS_OFF_EVENTS, ev);
        rd(`UCMS_OFF_CYCLES, cy);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_defaults;
        rd(`UCMS_OFF_CTRL, rdv); chk(rdv, `UCMS_CTRL_RESET);
        rd(`UCMS_OFF_GATE, rdv); chk(rdv, `UCMS_GATE_RESET_MS);
        rd(8'h18, rdv); chk(rsp, 2'h2); // unmapped read refused
        wr(8'h1c, 32'h1); chk(rsp, 2'h2); // unmapped write refused
        wr(`UCMS_OFF_CTRL, 32'h400); #1;
        chk({automatic_trigger_level, automatic_attenuation, sensitivity_mode}, 3'h1);
    endtask
    task automatic t_gate;
        logic [31:0] wv[5] = '{32'h0, 32'h1, 32'h1869f, 32'h186a0, 32'hffffffff};
        logic [31:0] ex[5] = '{32'h1, 32'h1, 32'h1869f, 32'h1869f, 32'h1869f};
        for (int i = 0; i < 5; i++)
        begin
            wr(`UCMS_OFF_GATE, wv[i]);
            rd(`UCMS_OFF_GATE, rdv); chk(rdv, ex[i]);
        end
    endtask
    task automatic t_freq;
        logic [31:0] p[3] = '{32'h6, 32'ha, 32'h4};
        for (int f = 0; f < 3; f++)
        begin
            measure(f, 32'h5);
            chk_in(cy, 32'h28, 32'h32);
            chk_in(ev * p[f], cy - p[f], cy + p[f]);
        end
        measure({29'h0, `UCMS_FN_PERIOD_A}, 32'h2);
        chk_in(ev, 32'h2, 32'h8);
        chk(cy, ev * 32'h6);
    endtask
    task automatic t_interval;
        logic [31:0] cf[5] = '{32'h4, 32'h1004, 32'hc, 32'h100c, 32'h804};
        logic [31:0] lo[5] = '{32'h2, 32'hc, 32'h13, 32'h9, 32'hc};
        @(posedge mclk);
        {ha, hb, lag} <= {32'ha, 32'ha, 32'h3};
        for (int i = 0; i < 5; i++)
        begin
            measure(cf[i], 32'h1);
            chk_in(cy, lo[i], lo[i] + 32'h2);
            chk(ev, 32'h1);
        end
        measure(32'h84, 32'h1);
        chk(ev, 32'h64);
        chk_in(cy, 32'hc8, 32'h190);
    endtask
    task automatic t_one_shot;
        wr(`UCMS_OFF_CTRL, 32'h44);
        wr(`UCMS_OFF_CMD, 32'h1);
        ws(2000, got, gap); chk(got, 1'b1);
        ws(300, got, gap); chk(got, 1'b0);
        wr(`UCMS_OFF_CMD, 32'h1);
        ws(2000, got, gap); chk(got, 1'b1);
        wr(`UCMS_OFF_GATE, 32'h5);
        wr(`UCMS_OFF_CTRL, 32'h4);
        ws(2000, got, gap);
        ws(2000, got, gap); chk_in(gap, 32'h32, 32'h50);
    endtask
    task automatic t_arm;
        @(posedge mclk);
        ha <= 32'h3;
        wr(`UCMS_OFF_CTRL, 32'h10);
        wr(`UCMS_OFF_CMD, 32'h1);
        ws(300, got, gap); chk(got, 1'b0);
        @(posedge mclk);
        aen <= 1'b1;
        measure(32'h10, 32'h2);
        chk_in(cy, 32'h55, 32'h65);
        measure(32'h30, 32'h2);
        chk_in(cy, 32'ha, 32'h15);
    endtask
    // ==========================================================
    // main sequence and hang guard
    initial
    begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        t_defaults();
        t_gate();
        t_freq();
        t_interval();
        t_one_shot();
        t_arm();
        complete_run();
    end
    initial
    begin
        repeat (100000) @(posedge mclk);
        err_count++;
        complete_run();
    end
endmodule // universal_counter_measure_seq_test
`default_nettype wire
